// ### shared/rtcf_pkg.sv
// Package with register map, field layout and types of the RTC event block.
package rtcf_pkg;

  localparam logic [7:0] ALARM_B_SUBSECOND_MATCH_OFS = 8'h4C;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h50;
  localparam logic [7:0] MASKED_INTERRUPT_STATUS_OFS = 8'h54;
  localparam logic [7:0] STATUS_CLEAR_OFS = 8'h5C;
  // Control register holding enables and the interrupt enables.
  localparam logic [7:0] EVENT_CONTROL_OFS = 8'h60;

  localparam logic [31:0] REG_RESET_VAL = 32'h00000000;
  localparam int SS_WIDTH = 15;
  localparam int SS_LSB = 0;
  localparam int MASK_LSB = 24;
  localparam int MASK_WIDTH = 4;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_FULL = 4'hF;

  localparam int FLAG_ALARM_A = 0;
  localparam int FLAG_ALARM_B = 1;
  localparam int FLAG_WAKEUP = 2;
  localparam int FLAG_STAMP = 3;
  localparam int FLAG_STAMP_OVF = 4;
  localparam int FLAG_INT_STAMP = 5;
  localparam int FLAG_COUNT = 6;

  // Control register fields.
  localparam int CTL_ALARM_B_ENABLE = 8;
  localparam int CTL_INIT_MODE = 7;
  localparam int CTL_IE_LSB = 0;

  // Clear pipeline depth: a flag drops two bus clocks after the write.
  localparam int CLEAR_DELAY = 2;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } rtcf_bus_req_t;

  typedef struct packed {
    logic int_stamp;
    logic stamp;
    logic wakeup;
    logic alarm_b_time;
    logic alarm_a;
  } rtcf_events_t;

endpackage : rtcf_pkg

// ### rtl/rtcf_event_flags.sv
// Alarm B sub-second match and RTC event flag registers with Avalon-MM slave.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
module rtcf_event_flags
  import rtcf_pkg::*;
(
  // Clock and domain reset.
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Avalon-MM slave.
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Calendar side.
  input wire logic WRITE_UNLOCKED,
  input wire logic [15:0] SUBSECOND_COUNT,
  input wire logic SECOND_UNIT_TICK,
  input wire logic ALARM_B_FIELDS_MATCH,
  input wire logic ALARM_A_MATCH,
  input wire logic WAKEUP_REACHED_ZERO,
  input wire logic STAMP_EVENT,
  input wire logic INTERNAL_STAMP_EVENT,
  // Event outputs.
  output logic [FLAG_COUNT-1:0] EVENT_FLAGS,
  output logic [FLAG_COUNT-1:0] MASKED_FLAGS,
  output logic ALARM_B_ENABLE
);

  // Mask of compared sub-second bits for a mask count.
  function automatic logic [SS_WIDTH-1:0] ss_mask(input logic [3:0] n);
    logic [SS_WIDTH:0] m;
    m = (16'h0001 << n) - 16'h0001;
    if (n == MASK_FULL) begin
      m = 16'h7FFF;
    end
    return m[SS_WIDTH-1:0];
  endfunction : ss_mask

  rtcf_bus_req_t req;
  logic [SS_WIDTH-1:0] ss_match_q;
  logic [3:0] subsecond_mask_count_q;
  logic [FLAG_COUNT-1:0] flags_q;
  logic [FLAG_COUNT-1:0] flags_d;
  logic [FLAG_COUNT-1:0] clr_p1_q;
  logic [FLAG_COUNT-1:0] clr_p2_q;
  logic [8:0] ctl_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic waitreq_q;
  logic [FLAG_COUNT-1:0] masked_q;

  assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                 writedata: AVS_WRITEDATA};

  // One wait state: the access completes on the edge after ack_q rises.
  wire access = (req.read | req.write) & ~ack_q;
  wire wr_take = req.write & ~ack_q;
  wire rd_take = req.read & ~ack_q;
  wire sel_ss = req.address == ALARM_B_SUBSECOND_MATCH_OFS;
  wire sel_clr = req.address == STATUS_CLEAR_OFS;
  wire sel_ctl = req.address == EVENT_CONTROL_OFS;
  wire [FLAG_COUNT-1:0] irq_en = ctl_q[CTL_IE_LSB +: FLAG_COUNT];
  wire init_mode = ctl_q[CTL_INIT_MODE];
  wire alarm_b_en = ctl_q[CTL_ALARM_B_ENABLE];

  // Write gate: protection unlocked and alarm disabled or in init mode.
  wire ss_write_ok = WRITE_UNLOCKED & (~alarm_b_en | init_mode);
  wire ss_wr = wr_take & sel_ss & ss_write_ok;

  // Sub-second comparison, bit 15 excluded.
  wire [SS_WIDTH-1:0] cmp_mask = ss_mask(subsecond_mask_count_q);
  wire [SS_WIDTH-1:0] ss_now = SUBSECOND_COUNT[SS_WIDTH-1:0];
  wire ss_equal = ((ss_now ^ ss_match_q) & cmp_mask) == '0;
  wire ss_hit = (subsecond_mask_count_q == MASK_NONE) ?
                SECOND_UNIT_TICK : ss_equal;
  wire alarm_b_event = alarm_b_en & ALARM_B_FIELDS_MATCH & ss_hit;

  wire stamp_any = STAMP_EVENT | INTERNAL_STAMP_EVENT;
  wire [FLAG_COUNT-1:0] set_vec = {
    INTERNAL_STAMP_EVENT,
    stamp_any & flags_q[FLAG_STAMP],
    stamp_any,
    WAKEUP_REACHED_ZERO,
    alarm_b_event,
    ALARM_A_MATCH
  };

  // Each clear bit targets its own flag position.
  wire [FLAG_COUNT-1:0] clr_req = (wr_take & sel_clr) ?
      req.writedata[FLAG_COUNT-1:0] : '0;

  // Set wins over a clear arriving in the same cycle.
  assign flags_d = (flags_q & ~clr_p2_q) | set_vec;

  wire [31:0] rd_mux =
      sel_ss ? {4'h0, subsecond_mask_count_q, 9'h000, ss_match_q} :
      (req.address == EVENT_STATUS_OFS) ? {26'h0, flags_q} :
      (req.address == MASKED_INTERRUPT_STATUS_OFS) ? {26'h0, masked_q} :
      sel_ctl ? {23'h0, ctl_q} : 32'h00000000;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ss_match_q <= '0;
      subsecond_mask_count_q <= '0;
      flags_q <= '0;
      clr_p1_q <= '0;
      clr_p2_q <= '0;
      ctl_q <= '0;
      masked_q <= '0;
      rdata_q <= REG_RESET_VAL;
      ack_q <= 1'b0;
      waitreq_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      masked_q <= flags_d & irq_en;
      clr_p1_q <= clr_req;
      clr_p2_q <= clr_p1_q;
      ack_q <= access;
      waitreq_q <= ~access;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
      if (ss_wr) begin
        ss_match_q <= req.writedata[SS_LSB +: SS_WIDTH];
        subsecond_mask_count_q <= req.writedata[MASK_LSB +: MASK_WIDTH];
      end
      if (wr_take & sel_ctl) begin
        ctl_q <= req.writedata[8:0];
      end
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EVENT_FLAGS <= '0;
      MASKED_FLAGS <= '0;
      ALARM_B_ENABLE <= 1'b0;
    end else begin
      EVENT_FLAGS <= flags_d;
      MASKED_FLAGS <= flags_d & irq_en;
      ALARM_B_ENABLE <= alarm_b_en;
    end
  end

  // Wait request is its own flop so the pin is not driven through a gate.
  assign AVS_WAITREQUEST = waitreq_q;
  assign AVS_READDATA = rdata_q;

  a_clear_two_cycles: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (wr_take && sel_clr && req.writedata[FLAG_WAKEUP] && !WAKEUP_REACHED_ZERO)
    ##2 !WAKEUP_REACHED_ZERO |=> !flags_q[FLAG_WAKEUP])
    else $error("wakeup flag not cleared two cycles after write");
  a_clear_not_early: assert property (@(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_ALARM_A] && !(|clr_p2_q) |=> flags_q[FLAG_ALARM_A])
    else $error("alarm A flag dropped without a clear");
  a_stamp_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
    STAMP_EVENT |=> flags_q[FLAG_STAMP])
    else $error("stamp flag not set");
  a_ovf_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
    STAMP_EVENT && flags_q[FLAG_STAMP] |=> flags_q[FLAG_STAMP_OVF])
    else $error("overflow flag not set");
  a_ovf_cause: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_STAMP_OVF]) |-> $past(flags_q[FLAG_STAMP]))
    else $error("overflow set without pending stamp");
  a_int_stamp: assert property (@(posedge MCLK) disable iff (SYS_RST)
    INTERNAL_STAMP_EVENT |=> flags_q[FLAG_INT_STAMP] && flags_q[FLAG_STAMP])
    else $error("internal stamp flags not set");
  a_wakeup_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
    WAKEUP_REACHED_ZERO |=> flags_q[FLAG_WAKEUP])
    else $error("wakeup flag not set");
  a_alarm_a_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
    ALARM_A_MATCH |=> flags_q[FLAG_ALARM_A])
    else $error("alarm A flag not set");
  a_masked_gate: assert property (@(posedge MCLK) disable iff (SYS_RST)
    masked_q == (flags_q & irq_en))
    else $error("masked status differs from gated flags");
  a_mask_full: assert property (@(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q == MASK_FULL && alarm_b_en &&
    ALARM_B_FIELDS_MATCH && ss_now != ss_match_q |-> !alarm_b_event)
    else $error("alarm B fired on partial sub-second match");
  a_mask_none: assert property (@(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q == MASK_NONE && alarm_b_en &&
    ALARM_B_FIELDS_MATCH && SECOND_UNIT_TICK |=> flags_q[FLAG_ALARM_B])
    else $error("alarm B missed with mask zero");
  a_mask_one: assert property (@(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q == 4'h1 && alarm_b_en && ALARM_B_FIELDS_MATCH &&
    ss_now[0] == ss_match_q[0] |-> alarm_b_event)
    else $error("alarm B missed with mask one");
  a_bit15_ignored: assert property (@(posedge MCLK) disable iff (SYS_RST)
    ss_equal == (((ss_now ^ ss_match_q) & cmp_mask) == 15'h0000))
    else $error("sub-second compare width wrong");
  a_protect_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
    wr_take && sel_ss && !WRITE_UNLOCKED |=> $stable(ss_match_q))
    else $error("protected sub-second write took effect");

  // Each clear bit drops its own flag once the pipeline delivers it.
  a_clr_alarm_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_ALARM_A] && !set_vec[FLAG_ALARM_A] |=>
    !flags_q[FLAG_ALARM_A])
    else $error("alarm A flag not cleared");
  a_clr_alarm_b: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_ALARM_B] && !set_vec[FLAG_ALARM_B] |=>
    !flags_q[FLAG_ALARM_B])
    else $error("alarm B flag not cleared");
  a_clr_wakeup: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_WAKEUP] && !set_vec[FLAG_WAKEUP] |=>
    !flags_q[FLAG_WAKEUP])
    else $error("wakeup flag not cleared");
  a_clr_stamp: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_STAMP] && !set_vec[FLAG_STAMP] |=>
    !flags_q[FLAG_STAMP])
    else $error("stamp flag not cleared");
  a_clr_stamp_ovf: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_STAMP_OVF] && !set_vec[FLAG_STAMP_OVF] |=>
    !flags_q[FLAG_STAMP_OVF])
    else $error("overflow flag not cleared");
  a_clr_int_stamp: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    clr_p2_q[FLAG_INT_STAMP] && !set_vec[FLAG_INT_STAMP] |=>
    !flags_q[FLAG_INT_STAMP])
    else $error("internal stamp flag not cleared");

  // A flag holds until its own clear bit arrives.
  a_hold_alarm_b: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_ALARM_B] && !clr_p2_q[FLAG_ALARM_B] |=>
    flags_q[FLAG_ALARM_B])
    else $error("alarm B flag dropped without a clear");
  a_hold_wakeup: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_WAKEUP] && !clr_p2_q[FLAG_WAKEUP] |=>
    flags_q[FLAG_WAKEUP])
    else $error("wakeup flag dropped without a clear");
  a_hold_stamp: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_STAMP] && !clr_p2_q[FLAG_STAMP] |=>
    flags_q[FLAG_STAMP])
    else $error("stamp flag dropped without a clear");
  a_hold_stamp_ovf: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_STAMP_OVF] && !clr_p2_q[FLAG_STAMP_OVF] |=>
    flags_q[FLAG_STAMP_OVF])
    else $error("overflow flag dropped without a clear");
  a_hold_int_stamp: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    flags_q[FLAG_INT_STAMP] && !clr_p2_q[FLAG_INT_STAMP] |=>
    flags_q[FLAG_INT_STAMP])
    else $error("internal stamp flag dropped without a clear");
  a_clr_pipe: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    1'b1 |=> clr_p2_q == $past(clr_p1_q))
    else $error("clear pipeline stage skipped");

  // Flags rise only on their own events.
  a_alarm_b_sets: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    alarm_b_event |=> flags_q[FLAG_ALARM_B])
    else $error("alarm B flag not set");
  a_alarm_b_cause: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_ALARM_B]) |-> $past(alarm_b_event))
    else $error("alarm B flag set without a match");
  a_alarm_b_gate: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !alarm_b_en |-> !alarm_b_event)
    else $error("alarm B fired while disabled");
  a_wakeup_cause: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_WAKEUP]) |-> $past(WAKEUP_REACHED_ZERO))
    else $error("wakeup flag set without an event");
  a_alarm_a_cause: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_ALARM_A]) |-> $past(ALARM_A_MATCH))
    else $error("alarm A flag set without a match");
  a_stamp_cause: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_STAMP]) |-> $past(stamp_any))
    else $error("stamp flag set without an event");
  a_int_cause: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $rose(flags_q[FLAG_INT_STAMP]) |-> $past(INTERNAL_STAMP_EVENT))
    else $error("internal stamp flag set without an event");

  // Sub-second mask shaping.
  a_mask_zero_tick: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q == MASK_NONE && !SECOND_UNIT_TICK |->
    !alarm_b_event)
    else $error("alarm B fired with mask zero and no tick");
  a_mask_miss: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q != MASK_NONE && !ss_equal |-> !alarm_b_event)
    else $error("alarm B fired on sub-second mismatch");
  a_mask_top_bit: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q != MASK_NONE |->
    cmp_mask[SS_WIDTH-1] == (subsecond_mask_count_q == MASK_FULL))
    else $error("top sub-second bit compare wrong");
  a_mask_low_bit: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    subsecond_mask_count_q != MASK_NONE |-> cmp_mask[0])
    else $error("lowest sub-second bit not compared");

  // Register bus and write gating.
  a_wait_answer: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    access |=> !AVS_WAITREQUEST)
    else $error("access not answered after one wait state");
  a_wait_one: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait request low for more than one cycle");
  a_read_capture: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    rd_take |=> AVS_READDATA == $past(rd_mux))
    else $error("read data not captured");
  a_read_hold: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !rd_take |=> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  a_ss_store: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    ss_wr |=> ss_match_q == $past(req.writedata[SS_LSB +: SS_WIDTH]))
    else $error("sub-second match value not stored");
  a_enabled_refuse: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    wr_take && sel_ss && alarm_b_en && !init_mode |=>
    $stable(subsecond_mask_count_q) && $stable(ss_match_q))
    else $error("sub-second write taken while alarm enabled");
  a_ports_follow: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    EVENT_FLAGS == flags_q && MASKED_FLAGS == masked_q)
    else $error("flag outputs differ from status");
  a_enable_port: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    1'b1 |=> ALARM_B_ENABLE == $past(alarm_b_en))
    else $error("alarm B enable output wrong");

endmodule : rtcf_event_flags

// ### dv/rtcf_event_flags_test.sv
// Self-checking bench for the event flags and alarm B sub-second block.
`timescale 1ns/10ps
module rtcf_event_flags_test;
  import rtcf_pkg::*;
  logic MCLK = 0, SYS_RST = 1, AVS_READ = 0, AVS_WRITE = 0, unl = 1;
  logic fm = 0, tk = 0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic [15:0] cnt = 16'h0;
  logic [3:0] ev = 4'h0;
  logic [5:0] flg, mflg;
  logic abe, AVS_WAITREQUEST;
  logic [7:0] ofs [5] = '{8'h4C, 8'h50, 8'h54, 8'h5C, 8'h80};
  int err_count = 0, tests_run = 0, cyc = 0;
  rtcf_event_flags rtcf_event_flags_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .WRITE_UNLOCKED(unl),
    .SUBSECOND_COUNT(cnt), .SECOND_UNIT_TICK(tk),
    .ALARM_B_FIELDS_MATCH(fm), .ALARM_A_MATCH(ev[0]),
    .WAKEUP_REACHED_ZERO(ev[1]), .STAMP_EVENT(ev[2]),
    .INTERNAL_STAMP_EVENT(ev[3]), .EVENT_FLAGS(flg), .MASKED_FLAGS(mflg),
    .ALARM_B_ENABLE(abe));
  always #10 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One Avalon access; a spare edge first keeps release and raise apart.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 0;
    AVS_WRITE <= 0;
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    check(nm, q, e);
  endtask : rd
  task automatic pulse(input logic [3:0] e);
    @(posedge MCLK);
    ev <= e;
    @(posedge MCLK);
    ev <= 0;
    repeat (2) @(posedge MCLK);
  endtask : pulse
  // Clears bits d, which must be set, and checks the two-cycle lag.
  task automatic clr(input logic [5:0] d);
    bus(1, STATUS_CLEAR_OFS, {26'h0, d});
    for (int k = 0; k < 3; k++) begin
      #1 check("clear lag", flg & d, (k < 1) ? d : 6'h0);
      if (k < 2) @(posedge MCLK);
    end
  endtask : clr
  function automatic logic fire(int n, logic [14:0] v, logic [15:0] c,
      logic f, t);
    logic [14:0] m;
    m = 15'h7FFF >> (15 - n);
    return f && ((n == 0) ? t : (((v ^ c[14:0]) & m) == 15'h0));
  endfunction : fire
  initial begin
    logic [31:0] v, c, ie;
    int n;
    logic [5:0] ex [4] = '{6'h01, 6'h05, 6'h0D, 6'h3D};
    void'($urandom(90));
    repeat (3) @(posedge MCLK);
    SYS_RST <= 0;
    foreach (ofs[i]) rd("reset", ofs[i], 32'h0);
    unl <= 0;
    bus(1, ALARM_B_SUBSECOND_MATCH_OFS, 32'h0F007FFF);
    rd("locked", ALARM_B_SUBSECOND_MATCH_OFS, 32'h0);
    unl <= 1;
    bus(1, EVENT_CONTROL_OFS, 32'h100);
    bus(1, ALARM_B_SUBSECOND_MATCH_OFS, 32'h0F007FFF);
    rd("enabled", ALARM_B_SUBSECOND_MATCH_OFS, 32'h0);
    ie = {$urandom} & 32'h3F;
    bus(1, EVENT_CONTROL_OFS, 32'h180 | ie);
    #1 check("enable", abe, 1'b1);
    bus(1, ALARM_B_SUBSECOND_MATCH_OFS, 32'hFFFFFFFF);
    rd("fields", ALARM_B_SUBSECOND_MATCH_OFS, 32'h0F007FFF);
    bus(1, 8'h80, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      check("flags", flg, ex[i]);
    end
    rd("masked", MASKED_INTERRUPT_STATUS_OFS, ie & 32'h3D);
    check("masked port", mflg, ie[5:0] & 6'h3D);
    bus(1, STATUS_CLEAR_OFS, 32'h0);
    rd("zero clear", EVENT_STATUS_OFS, 32'h3D);
    clr(6'h28);
    clr(6'h10);
    clr(6'h04);
    clr(6'h01);
    rd("cleared", EVENT_STATUS_OFS, 32'h0);
    for (int t = 0; t < 40; t++) begin
      n = (t < 16) ? t : $urandom_range(15);
      v = $urandom;
      c = $urandom;
      bus(1, ALARM_B_SUBSECOND_MATCH_OFS, {4'h0, n[3:0], 9'h0, v[14:0]});
      @(posedge MCLK);
      cnt <= {c[15], v[14:0] ^ (c[0] ? 15'h1 << c[7:4] : 15'h0)};
      fm <= c[1] | c[2];
      tk <= c[3];
      @(posedge MCLK);
      fm <= 0;
      tk <= 0;
      repeat (2) @(posedge MCLK);
      check("alarm b", flg[FLAG_ALARM_B], fire(n, v[14:0], {c[15],
        v[14:0] ^ (c[0] ? 15'h1 << c[7:4] : 15'h0)}, c[1] | c[2], c[3]));
      bus(1, STATUS_CLEAR_OFS, 32'h2);
      repeat (3) @(posedge MCLK);
    end
    print_verdict();
  end
endmodule : rtcf_event_flags_test
